// ### core/abi_break_logic.sv
// Analyzer-side interface and break logic of the bus preprocessor board.
// Assumes an APB master on clock and an analyzer driving asynchronous strobes.
//
// The placing of the registers and register access over APB were decided locally.
`default_nettype none

module abi_break_logic
    import abi_pkg::*;
#(
    parameter logic [ABI_DATA_W-1:0] ID_CODE = 8'h5a // Arbitrary identity value
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ABI_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Analyzer interface bus
    input wire logic idReadStrobeN,
    input wire logic statusReadStrobeN,
    input wire logic secIdReadStrobeN,
    input wire logic interfaceMasterResetStrobeN,
    input wire logic haltClearStrobeN,
    input wire logic stimulusLine,
    input wire logic haltLine,
    input wire logic [ABI_DATA_W-1:0] internalIdDataLinesIn,
    output logic [ABI_DATA_W-1:0] internalIdDataLinesOut,
    output logic internalIdDataLinesOe
);
    logic [ABI_STROBE_W-1:0] strobeSyncN;
    logic [ABI_LINE_W-1:0] lineSync;
    logic [ABI_STROBE_W-1:0] strobeRise;
    logic [ABI_STROBE_W-1:0] strobeFall;
    logic [ABI_LINE_W-1:0] lineRise;
    logic [ABI_LINE_W-1:0] lineFall;

    logic [ABI_DATA_W-1:0] ctrl_ff;
    logic [ABI_DATA_W-1:0] secId_ff;
    logic [ABI_HADDR_W-1:0] hostAddr_ff;
    logic stimBrk_ff;
    logic haltBrk_ff;
    logic haltArmed_ff;
    logic [ABI_IRQ_W-1:0] intStat_ff;
    logic [ABI_IRQ_W-1:0] intMask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [ABI_DATA_W-1:0] dataOut_ff;
    logic dataOe_ff;

    logic [ABI_DATA_W-1:0] statusWord;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic addrHit;
    logic apbWr;
    logic apbAcc;
    logic idRd;
    logic statRd;
    logic secRd;
    logic mrPulse;
    logic hclrPulse;
    logic stimEvent;
    logic haltEvent;
    logic hostSet;
    logic hostClr;
    logic [ABI_IRQ_W-1:0] irqEvents;

    // Analyzer inputs are asynchronous; strobes idle high
    abi_sync #(.WIDTH(ABI_STROBE_W), .INIT(ABI_STROBE_IDLE)) u_strobe_sync (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .din({haltClearStrobeN, interfaceMasterResetStrobeN, secIdReadStrobeN,
              statusReadStrobeN, idReadStrobeN}),
        .dout(strobeSyncN)
    );

    abi_sync #(.WIDTH(ABI_LINE_W), .INIT(ABI_LINE_IDLE)) u_line_sync (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .din({haltLine, stimulusLine}),
        .dout(lineSync)
    );

    abi_edge #(.WIDTH(ABI_STROBE_W), .INIT(ABI_STROBE_IDLE)) u_strobe_edge (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(strobeSyncN),
        .rise(strobeRise),
        .fall(strobeFall)
    );

    abi_edge #(.WIDTH(ABI_LINE_W), .INIT(ABI_LINE_IDLE)) u_line_edge (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .level(lineSync),
        .rise(lineRise),
        .fall(lineFall)
    );

    // Read strobes are levels; control strobes act on the falling edge only
    assign idRd = ~strobeSyncN[ABI_SB_ID];
    assign statRd = ~strobeSyncN[ABI_SB_STATUS];
    assign secRd = ~strobeSyncN[ABI_SB_SECID];
    assign mrPulse = strobeFall[ABI_SB_MRST];
    assign hclrPulse = strobeFall[ABI_SB_HCLR];

    assign stimEvent = lineRise[ABI_LN_STIM] & ~ctrl_ff[ABI_STIM_DIS_BIT];
    assign haltEvent = lineRise[ABI_LN_HALT] & haltArmed_ff & ~ctrl_ff[ABI_HALT_DIS_BIT];

    // Same word serves host and analyzer so the two views cannot drift
    always_comb begin
        statusWord = {ctrl_ff[3:0], 1'b0, haltArmed_ff, haltBrk_ff, stimBrk_ff};
    end

    // APB: one wait state, answer registered
    assign apbAcc = psel & penable & ~pready_ff;
    assign apbWr = ce & psel & penable & pready_ff & pwrite;
    assign hostSet = apbWr && paddr == ABI_BRKCMD_OFF && pwdata[ABI_BRK_SET_BIT];
    assign hostClr = apbWr && paddr == ABI_BRKCMD_OFF && pwdata[ABI_BRK_CLR_BIT];

    always_comb begin
        addrHit = 1'b1;
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            ABI_CTRL_OFF: nxt_prdata[ABI_DATA_W-1:0] = ctrl_ff;
            ABI_SECID_OFF: nxt_prdata[ABI_DATA_W-1:0] = secId_ff;
            ABI_STATUS_OFF: nxt_prdata[ABI_DATA_W-1:0] = statusWord;
            ABI_BRKCMD_OFF: nxt_prdata = 32'h0000_0000;
            ABI_HADDR_OFF: nxt_prdata[ABI_HADDR_W-1:0] = hostAddr_ff;
            ABI_INTSTAT_OFF: nxt_prdata[ABI_IRQ_W-1:0] = intStat_ff;
            ABI_INTMASK_OFF: nxt_prdata[ABI_IRQ_W-1:0] = intMask_ff;
            default: addrHit = 1'b0;
        endcase
        nxt_pslverr = ~addrHit;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (ce) begin
            pready_ff <= apbAcc;
            if (apbAcc) begin
                pslverr_ff <= nxt_pslverr;
                prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Host configuration; master reset overrides a coincident write, except a write to the interrupt mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= ABI_CTRL_RST;
            secId_ff <= ABI_SECID_RST;
            hostAddr_ff <= ABI_HADDR_RST;
            intMask_ff <= ABI_IRQ_RST;
        end else if (ce) begin
            if (mrPulse) begin
                ctrl_ff <= ABI_CTRL_RST;
                secId_ff <= ABI_SECID_RST;
                hostAddr_ff <= ABI_HADDR_RST;
            end else if (apbWr) begin
                if (paddr == ABI_CTRL_OFF) begin
                    ctrl_ff <= pwdata[ABI_DATA_W-1:0];
                end
                if (paddr == ABI_SECID_OFF) begin
                    secId_ff <= pwdata[ABI_DATA_W-1:0];
                end
                if (paddr == ABI_HADDR_OFF) begin
                    hostAddr_ff <= pwdata[ABI_HADDR_W-1:0];
                end
            end
            if (apbWr && paddr == ABI_INTMASK_OFF) begin
                intMask_ff <= pwdata[ABI_IRQ_W-1:0];
            end
        end
    end

    // Breaks: hardware events win over a host reset in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stimBrk_ff <= 1'b0;
            haltBrk_ff <= 1'b0;
        end else if (ce) begin
            if (mrPulse) begin
                stimBrk_ff <= 1'b0;
                haltBrk_ff <= 1'b0;
            end else begin
                if (hostClr) begin
                    stimBrk_ff <= 1'b0;
                    haltBrk_ff <= 1'b0;
                end
                if (hostSet) begin
                    stimBrk_ff <= 1'b1;
                    haltBrk_ff <= 1'b1;
                end
                if (stimEvent) begin
                    stimBrk_ff <= 1'b1;
                end
                if (haltEvent) begin
                    haltBrk_ff <= 1'b1;
                end
            end
        end
    end

    // Halt capture is one-shot; clear strobe re-arms it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            haltArmed_ff <= 1'b0;
        end else if (ce) begin
            if (mrPulse) begin
                haltArmed_ff <= 1'b0;
            end else if (hclrPulse) begin
                haltArmed_ff <= 1'b1;
            end else if (haltEvent) begin
                haltArmed_ff <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    assign irqEvents = {mrPulse, haltEvent, stimEvent};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            intStat_ff <= ABI_IRQ_RST;
            irq_ff <= 1'b0;
        end else if (ce) begin
            if (apbWr && paddr == ABI_INTSTAT_OFF) begin
                intStat_ff <= (intStat_ff & ~pwdata[ABI_IRQ_W-1:0]) | irqEvents;
            end else begin
                intStat_ff <= intStat_ff | irqEvents;
            end
            irq_ff <= |(intStat_ff & intMask_ff);
        end
    end

    // Analyzer read data; ID strobe has priority so the others stay off
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataOut_ff <= ~8'h00;
            dataOe_ff <= 1'b0;
        end else if (ce) begin
            dataOe_ff <= idRd | statRd | secRd;
            if (idRd) begin
                dataOut_ff <= ~ID_CODE;
            end else if (secRd) begin
                dataOut_ff <= ~secId_ff;
            end else if (statRd) begin
                dataOut_ff <= ~statusWord;
            end else begin
                dataOut_ff <= ~8'h00;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign internalIdDataLinesOut = dataOut_ff;
    assign internalIdDataLinesOe = dataOe_ff;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    id_code_out_a: assert property (
        ce && idRd |=> dataOe_ff && dataOut_ff == ~ID_CODE
    ) else $error("ID read did not return the fixed code");

    id_exclusive_a: assert property (
        ce && idRd && (statRd || secRd) |=> dataOut_ff == ~ID_CODE
    ) else $error("Other driver active during ID read");

    secid_readback_a: assert property (
        ce && secRd && !idRd |=> dataOut_ff == ~$past(secId_ff)
    ) else $error("Secondary ID read back changed");

    status_mirror_a: assert property (
        ce && statRd && !idRd && !secRd |=> dataOut_ff == ~$past(statusWord)
    ) else $error("Analyzer status differs from host status");

    host_brk_set_a: assert property (
        hostSet && !mrPulse |=> stimBrk_ff && haltBrk_ff && statusWord[1:0] == 2'h3
    ) else $error("Host break set not shown in status");

    host_brk_clr_a: assert property (
        ce && hostClr && !hostSet && !mrPulse && !lineRise[ABI_LN_STIM] |=> !stimBrk_ff
    ) else $error("Host break reset not shown in status");

    mreset_load_a: assert property (
        mrPulse |=> secId_ff == ABI_SECID_RST && !stimBrk_ff && !haltBrk_ff
    ) else $error("Master reset did not load ID and clear breaks");

    mreset_ctrl_a: assert property (
        mrPulse |=> ctrl_ff == ABI_CTRL_RST && hostAddr_ff == ABI_HADDR_RST
    ) else $error("Master reset left control or address latch");

    stim_break_a: assert property (
        lineRise[ABI_LN_STIM] && !ctrl_ff[ABI_STIM_DIS_BIT] && !mrPulse |=> stimBrk_ff
    ) else $error("Stimulus break not raised");

    stim_disable_a: assert property (
        ce && !stimBrk_ff && ctrl_ff[ABI_STIM_DIS_BIT] && !hostSet |=> !stimBrk_ff
    ) else $error("Stimulus break set while disabled");

    halt_break_a: assert property (
        lineRise[ABI_LN_HALT] && haltArmed_ff && !ctrl_ff[ABI_HALT_DIS_BIT] && !mrPulse
            |=> haltBrk_ff && (!haltArmed_ff || $past(hclrPulse))
    ) else $error("Halt break not raised when armed");

    halt_disable_a: assert property (
        ce && !haltBrk_ff && ctrl_ff[ABI_HALT_DIS_BIT] && !hostSet |=> !haltBrk_ff
    ) else $error("Halt break set while disabled");

    halt_rearm_a: assert property (
        hclrPulse && !mrPulse |=> haltArmed_ff
    ) else $error("Halt clear did not re-arm capture");

    strobe_once_a: assert property (
        mrPulse |=> !mrPulse [*2]
    ) else $error("Master reset acted on more than once");
endmodule // abi_break_logic

`default_nettype wire

// ### core/abi_pkg.sv
// Shared constants for the analyzer interface and break logic block.
// Assumes a 32-bit APB host bus and an 8-bit negative-true analyzer data bus.
`default_nettype none

package abi_pkg;
    localparam int ABI_DATA_W = 8;
    localparam int ABI_ADDR_W = 8;
    localparam int ABI_HADDR_W = 16;
    localparam int ABI_IRQ_W = 3;
    localparam int ABI_STROBE_W = 5;
    localparam int ABI_LINE_W = 2;

    // APB byte offsets
    localparam logic [ABI_ADDR_W-1:0] ABI_CTRL_OFF = 8'h00;
    localparam logic [ABI_ADDR_W-1:0] ABI_SECID_OFF = 8'h04;
    localparam logic [ABI_ADDR_W-1:0] ABI_STATUS_OFF = 8'h08;
    localparam logic [ABI_ADDR_W-1:0] ABI_BRKCMD_OFF = 8'h0c;
    localparam logic [ABI_ADDR_W-1:0] ABI_HADDR_OFF = 8'h10;
    localparam logic [ABI_ADDR_W-1:0] ABI_INTSTAT_OFF = 8'h14;
    localparam logic [ABI_ADDR_W-1:0] ABI_INTMASK_OFF = 8'h18;

    // Reset values
    localparam logic [ABI_DATA_W-1:0] ABI_CTRL_RST = 8'h00;
    localparam logic [ABI_DATA_W-1:0] ABI_SECID_RST = 8'hff;
    localparam logic [ABI_HADDR_W-1:0] ABI_HADDR_RST = 16'h0000;
    localparam logic [ABI_IRQ_W-1:0] ABI_IRQ_RST = 3'h0;
    localparam logic [ABI_STROBE_W-1:0] ABI_STROBE_IDLE = 5'h1f;
    localparam logic [ABI_LINE_W-1:0] ABI_LINE_IDLE = 2'h0;

    // Control word fields
    localparam int ABI_HALT_DIS_BIT = 2;
    localparam int ABI_STIM_DIS_BIT = 3;

    // Break command fields
    localparam int ABI_BRK_SET_BIT = 0;
    localparam int ABI_BRK_CLR_BIT = 1;

    // Status word fields; bits 7:4 mirror control word bits 3:0
    localparam int ABI_ST_STIM_BIT = 0;
    localparam int ABI_ST_HALT_BIT = 1;
    localparam int ABI_ST_ARMED_BIT = 2;

    // Interrupt status fields
    localparam int ABI_IRQ_STIM_BIT = 0;
    localparam int ABI_IRQ_HALT_BIT = 1;
    localparam int ABI_IRQ_MRST_BIT = 2;

    // Analyzer strobe vector positions
    localparam int ABI_SB_ID = 0;
    localparam int ABI_SB_STATUS = 1;
    localparam int ABI_SB_SECID = 2;
    localparam int ABI_SB_MRST = 3;
    localparam int ABI_SB_HCLR = 4;

    // Analyzer break line positions
    localparam int ABI_LN_STIM = 0;
    localparam int ABI_LN_HALT = 1;
endpackage

`default_nettype wire

// ### core/abi_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes each bit is an independent level; no bus coherence is implied.
`default_nettype none

module abi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_ff <= INIT;
            dout <= INIT;
        end else if (ce) begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule // abi_sync

`default_nettype wire

// ### core/abi_edge.sv
// Edge detector giving one-cycle rise and fall pulses for synchronised levels.
// Assumes inputs are already in the clock domain.
`default_nettype none

module abi_edge #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_ff <= INIT;
        end else if (ce) begin
            prev_ff <= level;
        end
    end

    // Gated by ce so a frozen block never sees a stuck pulse
    assign rise = {WIDTH{ce}} & level & ~prev_ff;
    assign fall = {WIDTH{ce}} & ~level & prev_ff;
endmodule // abi_edge

`default_nettype wire

// ### test/abi_analyzer_model.sv
// Behavioural model of the analyzer control board on the interface bus.
// Assumes the bench clock; strobes and lines change just after a rising edge.
`default_nettype none

module abi_analyzer_model
    import abi_pkg::*;
(
    input wire logic clock,
    input wire logic [ABI_DATA_W-1:0] dataLines,
    output var logic [ABI_STROBE_W-1:0] strobeN,
    output var logic [ABI_LINE_W-1:0] lineHi
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        strobeN = ABI_STROBE_IDLE;
        lineHi = ABI_LINE_IDLE;
    end

    // One strobe at a time, held well past the two synchroniser stages
    task automatic readItem(input int sb, output logic [ABI_DATA_W-1:0] v);
        @(posedge clock);
        strobeN[sb] <= 1'b0;
        repeat (5) @(posedge clock);
        v = ~dataLines;
        strobeN[sb] <= 1'b1;
        repeat (5) @(posedge clock);
    endtask

    // Two strobes at once; the design must give one source priority
    task automatic readPair(input int sa, input int sb, output logic [ABI_DATA_W-1:0] v);
        @(posedge clock);
        strobeN <= ABI_STROBE_IDLE & ~((5'h01 << sa) | (5'h01 << sb));
        repeat (5) @(posedge clock);
        v = ~dataLines;
        strobeN <= ABI_STROBE_IDLE;
        repeat (5) @(posedge clock);
    endtask

    task automatic pulse(input int sb);
        @(posedge clock);
        strobeN[sb] <= 1'b0;
        repeat (3) @(posedge clock);
        strobeN[sb] <= 1'b1;
        repeat (5) @(posedge clock);
    endtask

    task automatic raise(input int ln);
        @(posedge clock);
        lineHi[ln] <= 1'b1;
        repeat (3) @(posedge clock);
        lineHi[ln] <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
endmodule // abi_analyzer_model

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the analyzer interface and break logic.
// Assumes abi_analyzer_model as the far side and an APB master in this module.
`default_nettype none

module tb
    import abi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] TB_ID = 8'h3c; // Arbitrary identity value

    logic clock, rst, ce, psel, penable, pwrite, pready, pslverr, irq, dataOe;
    logic [7:0] paddr, dataOut, busWire, floatVal;
    logic [31:0] pwdata, prdata;
    logic [4:0] strobeN;
    logic [1:0] lineHi;
    int fails = 0;
    int testsRun = 0;

    // Released lines float: show the inverse of the last driven value
    always @(posedge clock) if (dataOe) floatVal <= ~dataOut;
    assign busWire = dataOe ? dataOut : floatVal;

    abi_break_logic #(.ID_CODE(TB_ID)) dut_u (
        .clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .idReadStrobeN(strobeN[ABI_SB_ID]), .statusReadStrobeN(strobeN[ABI_SB_STATUS]),
        .secIdReadStrobeN(strobeN[ABI_SB_SECID]), .interfaceMasterResetStrobeN(strobeN[ABI_SB_MRST]),
        .haltClearStrobeN(strobeN[ABI_SB_HCLR]), .stimulusLine(lineHi[ABI_LN_STIM]),
        .haltLine(lineHi[ABI_LN_HALT]), .internalIdDataLinesIn(busWire),
        .internalIdDataLinesOut(dataOut), .internalIdDataLinesOe(dataOe));

    abi_analyzer_model ana_u (.clock(clock), .dataLines(busWire), .strobeN(strobeN), .lineHi(lineHi));

    task automatic giveVerdict;
        if (fails == 0 && testsRun > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
    endtask

    task automatic hostRd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 32'h0000_0000, r, er);
        chk(r, e, "host read");
    endtask

    task automatic anaChk(input int sb, input logic [7:0] e);
        logic [7:0] v;
        ana_u.readItem(sb, v);
        chk({24'h00_0000, v}, {24'h00_0000, e}, "analyzer read");
    endtask

    task automatic brk(input logic [1:0] e);
        logic [31:0] r;
        logic er;
        apb(1'b0, ABI_STATUS_OFF, 32'h0000_0000, r, er);
        chk({30'h0, r[1:0]}, {30'h0, e}, "break flags");
    endtask

    // Irq lags the register by one cycle
    task automatic irqChk(input logic e);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, {31'h0, e}, "irq");
    endtask

    task automatic resetValues;
        logic [31:0] r;
        logic er;
        hostRd(ABI_CTRL_OFF, 32'h0000_0000);
        hostRd(ABI_SECID_OFF, 32'h0000_00ff);
        anaChk(ABI_SB_ID, TB_ID);
        chk({31'h0, dataOe}, 32'h0000_0000, "lines released");
        apb(1'b0, 8'h40, 32'h0000_0000, r, er);
        chk({r[30:0], er}, 32'h0000_0001, "unmapped");
    endtask

    task automatic secIdWalk;
        logic [7:0] v;
        wr(ABI_CTRL_OFF, 32'h0000_000f);
        wr(ABI_BRKCMD_OFF, 32'h0000_0001);
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 8'h00 : (i == 9) ? 8'hff : 8'h80 >> (i - 1);
            wr(ABI_SECID_OFF, {24'h00_0000, v});
            anaChk(ABI_SB_SECID, v);
        end
        anaChk(ABI_SB_ID, TB_ID);
        ana_u.readPair(ABI_SB_ID, ABI_SB_SECID, v);
        chk({24'h00_0000, v}, {24'h00_0000, TB_ID}, "ID over secondary ID");
        ana_u.readPair(ABI_SB_SECID, ABI_SB_STATUS, v);
        chk({24'h00_0000, v}, 32'h0000_00ff, "secondary ID over status");
    endtask

    task automatic statusWord;
        hostRd(ABI_STATUS_OFF, 32'h0000_00f3);
        anaChk(ABI_SB_STATUS, 8'hf3);
        wr(ABI_BRKCMD_OFF, 32'h0000_0002);
        anaChk(ABI_SB_STATUS, 8'hf0);
        hostRd(ABI_STATUS_OFF, 32'h0000_00f0);
    endtask

    task automatic masterReset;
        wr(ABI_BRKCMD_OFF, 32'h0000_0001);
        wr(ABI_SECID_OFF, 32'h0000_0000);
        wr(ABI_HADDR_OFF, 32'h0000_1234);
        wr(ABI_INTMASK_OFF, 32'h0000_0004);
        irqChk(1'h0);
        ana_u.pulse(ABI_SB_MRST);
        anaChk(ABI_SB_SECID, 8'hff);
        anaChk(ABI_SB_STATUS, 8'h00);
        hostRd(ABI_CTRL_OFF, 32'h0000_0000);
        hostRd(ABI_HADDR_OFF, 32'h0000_0000);
        irqChk(1'h1);
        wr(ABI_INTMASK_OFF, 32'h0000_0000);
        irqChk(1'h0);
        wr(ABI_INTMASK_OFF, 32'h0000_0004);
        wr(ABI_INTSTAT_OFF, 32'h0000_0004);
        irqChk(1'h0);
    endtask

    task automatic stimHalt;
        wr(ABI_CTRL_OFF, 32'h0000_0007);
        wr(ABI_BRKCMD_OFF, 32'h0000_0002);
        // A frozen block must not see a line that came and went
        ce <= 1'b0;
        ana_u.raise(ABI_LN_STIM);
        ce <= 1'b1;
        brk(2'h0);
        ana_u.pulse(ABI_SB_HCLR);
        ana_u.raise(ABI_LN_STIM);
        ana_u.raise(ABI_LN_HALT);
        brk(2'h1);
        wr(ABI_CTRL_OFF, 32'h0000_000b);
        wr(ABI_BRKCMD_OFF, 32'h0000_0002);
        wr(ABI_INTMASK_OFF, 32'h0000_0002);
        wr(ABI_INTSTAT_OFF, 32'h0000_0007);
        ana_u.raise(ABI_LN_STIM);
        brk(2'h0);
        for (int k = 0; k < 2; k++) begin
            ana_u.pulse(ABI_SB_HCLR);
            ana_u.raise(ABI_LN_HALT);
            brk(2'h2);
            irqChk(1'h1);
            wr(ABI_BRKCMD_OFF, 32'h0000_0002);
            wr(ABI_INTSTAT_OFF, 32'h0000_0002);
            irqChk(1'h0);
        end
        // Capture is one-shot: no halt break without a fresh clear
        ana_u.raise(ABI_LN_HALT);
        brk(2'h0);
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        giveVerdict();
    end

    initial begin
        rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; floatVal = 8'h00;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        resetValues();
        secIdWalk();
        statusWord();
        masterReset();
        stimHalt();
        giveVerdict();
    end
endmodule // tb

`default_nettype wire
